// file: bkrc_pkg.sv
`default_nettype none
package bkrc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CPU_LATCH = 8'h32;
  localparam logic [7:0] ADDR_GFX_LATCH = 8'h33;
  localparam logic [7:0] ADDR_CPU_CTRL = 8'h35;
  localparam logic [7:0] ADDR_GFX_CTRL = 8'h36;
  localparam logic [7:0] ADDR_MEM_CTRL = 8'h37;

  // Reset values
  localparam logic [7:0] RST_CPU_LATCH = 8'h7f;
  localparam logic [7:0] RST_GFX_LATCH = 8'h7f;
  localparam logic [5:0] RST_CPU_CTRL = 6'h24;
  localparam logic [5:0] RST_GFX_CTRL = 6'h04;
  localparam logic [5:0] RST_MEM_CTRL = 6'h04;

  // Field layout
  localparam int STATE_LSB = 0;
  localparam int STATE_MSB = 2;
  localparam int EXIT_LSB = 3;
  localparam int EXIT_MSB = 5;
  localparam int CTRL_W = 6;
  localparam int CODE_MSB = 6;
  localparam int OVERRIDE_BIT = 7;
  localparam int CODE_W = 7;

  // ****************************************************************
  // State codes and decoded modes
  // ****************************************************************
  localparam logic [2:0] ST_OFF = 3'h4;
  localparam logic [2:0] ST_PFM = 3'h5;
  localparam logic [2:0] ST_APS = 3'h6;
  localparam logic [2:0] ST_PWM = 3'h7;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_PFM = 2'h1;
  localparam logic [1:0] MODE_APS = 2'h2;
  localparam logic [1:0] MODE_PWM = 2'h3;

  // ****************************************************************
  // Voltage code and slew timing
  // ****************************************************************
  localparam int REF_W = 14;                 // Reference in units of 0.1 mV
  localparam int VMIN_DMV = 3000;            // 0.3 V
  localparam int STEP_DMV = 125;             // 12.5 mV
  localparam logic [6:0] CODE_MAX = 7'h48;   // 72 steps reach 1.2 V
  localparam int CLK_MHZ = 200;
  localparam int SLEW_MV_PER_US = 25;
  localparam int STEP_UV = 12500;
  // Least time per code step, rounded up to whole cycles
  localparam int STEP_CYC = (STEP_UV * CLK_MHZ + SLEW_MV_PER_US * 1000 - 1)
                            / (SLEW_MV_PER_US * 1000);
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_CYC - 1);

  // ADC sample width and channel numbers of the fixed rails
  localparam int ADC_W = 10;
  localparam logic [1:0] ADC_CH_MEM = 2'h0;
  localparam logic [1:0] ADC_CH_PRE = 2'h1;

  // A state code selects a mode only when its top bit is set
  function automatic logic code_valid(input logic [2:0] c);
    code_valid = c[2];
  endfunction

  // Codes above the top step clamp to 1.2 V
  function automatic logic [6:0] code_clamp(input logic [6:0] c);
    code_clamp = (c > CODE_MAX) ? CODE_MAX : c;
  endfunction

  function automatic logic [REF_W-1:0] code_to_dmv(input logic [6:0] c);
    code_to_dmv = REF_W'(VMIN_DMV) + REF_W'(code_clamp(c)) * REF_W'(STEP_DMV);
  endfunction

endpackage
`default_nettype wire

// file: bkrc_ramp.sv
`timescale 1ns/1ps
`default_nettype none
module bkrc_ramp
  import bkrc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic step_en,
  input wire logic [6:0] target_code,
  output logic [6:0] ref_code,
  output logic [REF_W-1:0] ref_dmv
);

  typedef struct packed {
    logic [6:0] code;
    logic [REF_W-1:0] dmv;
  } bkrc_ramp_type;

  bkrc_ramp_type s_q, s_d;
  logic [6:0] goal;

  // ****************************************************************
  // One code step per slew tick, never a jump
  // ****************************************************************
  always_comb begin
    goal = code_clamp(target_code);
    s_d = s_q;
    if (step_en && goal > s_q.code) begin
      s_d.code = s_q.code + 7'h1;
    end else if (step_en && goal < s_q.code) begin
      s_d.code = s_q.code - 7'h1;
    end
    s_d.dmv = code_to_dmv(s_d.code);
  end

  // Reference starts at CODE_MAX, the clamped reset code of the latch register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{code: CODE_MAX, dmv: code_to_dmv(CODE_MAX)};
    end else begin
      s_q <= s_d;
    end
  end

  assign ref_code = s_q.code;
  assign ref_dmv = s_q.dmv;

  slew_limit_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (s_q.code != $past(s_q.code)) |-> $past(step_en) &&
    ((s_q.code == $past(s_q.code) + 7'h1) || (s_q.code == $past(s_q.code) - 7'h1)))
    else $error("reference moved without tick or by more than one step");

  ref_range_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ref_dmv == code_to_dmv(ref_code) && ref_code <= CODE_MAX)
    else $error("reference outside 0.3 to 1.2 V");

endmodule // bkrc_ramp
`default_nettype wire

// file: bkrc_isense.sv
`timescale 1ns/1ps
`default_nettype none
module bkrc_isense
  import bkrc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic adc_valid,
  input wire logic [1:0] adc_chan,
  input wire logic [ADC_W-1:0] adc_data,
  output logic [ADC_W-1:0] mem_current,
  output logic [ADC_W-1:0] pre_current
);

  typedef struct packed {
    logic [ADC_W-1:0] mem;
    logic [ADC_W-1:0] pre;
  } bkrc_isense_type;

  bkrc_isense_type s_q, s_d;

  // ****************************************************************
  // Converted load current of each fixed rail
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    if (adc_valid && adc_chan == ADC_CH_MEM) begin
      s_d.mem = adc_data;
    end
    if (adc_valid && adc_chan == ADC_CH_PRE) begin
      s_d.pre = adc_data;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign mem_current = s_q.mem;
  assign pre_current = s_q.pre;

  store_mem_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    adc_valid && adc_chan == ADC_CH_MEM |=> mem_current == $past(adc_data))
    else $error("memory rail current not stored");

  store_pre_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    adc_valid && adc_chan == ADC_CH_PRE |=> pre_current == $past(adc_data))
    else $error("preregulator current not stored");

endmodule // bkrc_isense
`default_nettype wire

// file: bkrc_top.sv
`timescale 1ns/1ps
`default_nettype none
module bkrc_top
  import bkrc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  // Register access port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Processor voltage-code pins
  input wire logic [6:0] voltage_code_bus,
  input wire logic [1:0] voltage_code_latch_enables,
  input wire logic standby_exit_pin,
  // Analog side
  input wire logic [3:0] overcurrent_detect,
  input wire logic adc_valid,
  input wire logic [1:0] adc_chan,
  input wire logic [ADC_W-1:0] adc_data,
  output logic [2:0] rail_enable,
  output logic [5:0] rail_mode,
  output logic [2:0] rail_discharge,
  output logic [6:0] cpu_core_ref_code,
  output logic [REF_W-1:0] cpu_core_ref_dmv,
  output logic [6:0] gfx_core_ref_code,
  output logic [REF_W-1:0] gfx_core_ref_dmv,
  output logic [ADC_W-1:0] memory_rail_current,
  output logic [ADC_W-1:0] preregulator_current,
  output logic cpu_core_overcurrent_flag,
  output logic gfx_core_overcurrent_flag,
  output logic memory_rail_overcurrent_flag,
  output logic preregulator_overcurrent_flag,
  output logic regulator_fault_irq
);

  typedef struct packed {
    logic [7:0] cpu_latch;
    logic [7:0] gfx_latch;
    logic [CTRL_W-1:0] cpu_ctrl;
    logic [CTRL_W-1:0] gfx_ctrl;
    logic [CTRL_W-1:0] mem_ctrl;
    logic [6:0] cpu_pin;
    logic [6:0] gfx_pin;
    logic [6:0] cpu_target;
    logic [6:0] gfx_target;
    logic [3:0] fault;
    logic irq;
    logic [2:0] enable;
    logic [5:0] mode;
    logic [2:0] discharge;
    logic [7:0] rdata;
    logic [DIV_W-1:0] div;
    logic step;
  } bkrc_top_type;

  bkrc_top_type s_q, s_d;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Register write into a control field; reserved bits are dropped
  function automatic logic [CTRL_W-1:0] ctrl_next(input logic [CTRL_W-1:0] cur,
                                                  input logic hit,
                                                  input logic [7:0] wd,
                                                  input logic exit_now);
    logic [CTRL_W-1:0] v;
    v = hit ? wd[CTRL_W-1:0] : cur;
    // Exit copy overrides a simultaneous state write
    if (exit_now && code_valid(v[EXIT_MSB:EXIT_LSB])) begin
      v[STATE_MSB:STATE_LSB] = v[EXIT_MSB:EXIT_LSB];
    end
    ctrl_next = v;
  endfunction

  // Reserved codes keep the mode already in force
  function automatic logic [1:0] mode_of(input logic [2:0] c, input logic [1:0] cur);
    logic [1:0] m;
    m = cur;
    unique case (c)
      ST_OFF: m = MODE_OFF;
      ST_PFM: m = MODE_PFM;
      ST_APS: m = MODE_APS;
      ST_PWM: m = MODE_PWM;
      default: m = cur;
    endcase
    mode_of = m;
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  logic [2:0] st_cpu, st_gfx, st_mem;

  always_comb begin
    s_d = s_q;
    // Host writes; latch registers take the full byte
    if (reg_wr && reg_addr == ADDR_CPU_LATCH) begin
      s_d.cpu_latch = reg_wdata;
    end
    if (reg_wr && reg_addr == ADDR_GFX_LATCH) begin
      s_d.gfx_latch = reg_wdata;
    end
    s_d.cpu_ctrl = ctrl_next(s_q.cpu_ctrl, reg_wr && reg_addr == ADDR_CPU_CTRL,
                             reg_wdata, standby_exit_pin);
    s_d.gfx_ctrl = ctrl_next(s_q.gfx_ctrl, reg_wr && reg_addr == ADDR_GFX_CTRL,
                             reg_wdata, standby_exit_pin);
    s_d.mem_ctrl = ctrl_next(s_q.mem_ctrl, reg_wr && reg_addr == ADDR_MEM_CTRL,
                             reg_wdata, standby_exit_pin);

    // Pins sampled on their latch enable into registers the host cannot reach
    if (voltage_code_latch_enables[0]) begin
      s_d.cpu_pin = voltage_code_bus;
    end
    if (voltage_code_latch_enables[1]) begin
      s_d.gfx_pin = voltage_code_bus;
    end

    // Code source: bit 7 set follows the register field
    s_d.cpu_target = s_d.cpu_latch[OVERRIDE_BIT] ? s_d.cpu_latch[CODE_MSB:0]
                                                 : s_d.cpu_pin;
    s_d.gfx_target = s_d.gfx_latch[OVERRIDE_BIT] ? s_d.gfx_latch[CODE_MSB:0]
                                                 : s_d.gfx_pin;

    // Decoded rail controls follow the new state field
    st_cpu = s_d.cpu_ctrl[STATE_MSB:STATE_LSB];
    st_gfx = s_d.gfx_ctrl[STATE_MSB:STATE_LSB];
    st_mem = s_d.mem_ctrl[STATE_MSB:STATE_LSB];
    s_d.mode = {mode_of(st_mem, s_q.mode[5:4]), mode_of(st_gfx, s_q.mode[3:2]),
                mode_of(st_cpu, s_q.mode[1:0])};
    s_d.enable = {s_d.mode[5:4] != MODE_OFF, s_d.mode[3:2] != MODE_OFF,
                  s_d.mode[1:0] != MODE_OFF};
    // Discharge holds for as long as the rail stays off
    s_d.discharge = ~s_d.enable;

    // Fault flags follow the comparators; any of them raises the interrupt
    s_d.fault = overcurrent_detect;
    s_d.irq = |overcurrent_detect;

    // Slew tick divider
    s_d.step = (s_q.div == DIV_LAST);
    s_d.div = s_d.step ? '0 : s_q.div + DIV_W'(1);

    // Read data; unmapped reads return zero
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CPU_LATCH: s_d.rdata = s_q.cpu_latch;
        ADDR_GFX_LATCH: s_d.rdata = s_q.gfx_latch;
        ADDR_CPU_CTRL: s_d.rdata = {2'h0, s_q.cpu_ctrl};
        ADDR_GFX_CTRL: s_d.rdata = {2'h0, s_q.gfx_ctrl};
        ADDR_MEM_CTRL: s_d.rdata = {2'h0, s_q.mem_ctrl};
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.cpu_latch <= RST_CPU_LATCH;
      s_q.gfx_latch <= RST_GFX_LATCH;
      s_q.cpu_ctrl <= RST_CPU_CTRL;
      s_q.gfx_ctrl <= RST_GFX_CTRL;
      s_q.mem_ctrl <= RST_MEM_CTRL;
      s_q.cpu_target <= RST_CPU_LATCH[CODE_MSB:0];
      s_q.gfx_target <= RST_GFX_LATCH[CODE_MSB:0];
      // Pin copies match the targets, so no ramp starts at release
      s_q.cpu_pin <= RST_CPU_LATCH[CODE_MSB:0];
      s_q.gfx_pin <= RST_GFX_LATCH[CODE_MSB:0];
      s_q.discharge <= '1; // All reset states decode to off
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Reference ramps and current store
  // ****************************************************************
  bkrc_ramp u_cpu_ramp (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .step_en(s_q.step),
    .target_code(s_q.cpu_target),
    .ref_code(cpu_core_ref_code),
    .ref_dmv(cpu_core_ref_dmv)
  );

  bkrc_ramp u_gfx_ramp (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .step_en(s_q.step),
    .target_code(s_q.gfx_target),
    .ref_code(gfx_core_ref_code),
    .ref_dmv(gfx_core_ref_dmv)
  );

  bkrc_isense u_isense (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .adc_valid(adc_valid),
    .adc_chan(adc_chan),
    .adc_data(adc_data),
    .mem_current(memory_rail_current),
    .pre_current(preregulator_current)
  );

  // Outputs straight from the state register
  assign reg_rdata = s_q.rdata;
  assign rail_enable = s_q.enable;
  assign rail_mode = s_q.mode;
  assign rail_discharge = s_q.discharge;
  assign cpu_core_overcurrent_flag = s_q.fault[0];
  assign gfx_core_overcurrent_flag = s_q.fault[1];
  assign memory_rail_overcurrent_flag = s_q.fault[2];
  assign preregulator_overcurrent_flag = s_q.fault[3];
  assign regulator_fault_irq = s_q.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  state_decode_a: assert property (
    s_q.cpu_ctrl[STATE_MSB:STATE_LSB] == ST_PWM |-> rail_mode[1:0] == MODE_PWM
    && rail_enable[0]) else $error("cpu rail mode does not match state field");

  exit_copy_a: assert property (
    standby_exit_pin && !reg_wr && code_valid(s_q.gfx_ctrl[EXIT_MSB:EXIT_LSB])
    |=> s_q.gfx_ctrl[STATE_MSB:STATE_LSB] == $past(s_q.gfx_ctrl[EXIT_MSB:EXIT_LSB]))
    else $error("standby exit did not copy");

  exit_skip_a: assert property (
    standby_exit_pin && !reg_wr && !code_valid(s_q.mem_ctrl[EXIT_MSB:EXIT_LSB])
    |=> $stable(s_q.mem_ctrl)) else $error("do-not-copy code changed state");

  src_select_a: assert property (
    !s_q.cpu_latch[OVERRIDE_BIT] && !voltage_code_latch_enables[0]
    |-> s_q.cpu_target == s_q.cpu_pin) else $error("pin code not followed");

  latch_capture_a: assert property (
    voltage_code_latch_enables[1] |=> s_q.gfx_pin == $past(voltage_code_bus))
    else $error("gfx latch missed the shared bus");

  fault_irq_a: assert property (
    overcurrent_detect[2] |=> memory_rail_overcurrent_flag && regulator_fault_irq)
    else $error("fault not raised");

  discharge_a: assert property (
    rail_mode[3:2] == MODE_OFF |-> rail_discharge[1] && !rail_enable[1])
    else $error("off rail not discharging");

  rsvd_read_a: assert property (
    reg_rd && reg_addr == ADDR_CPU_CTRL |=> reg_rdata[7:6] == 2'h0)
    else $error("reserved bits read nonzero");

  exit_cov: cover property (standby_exit_pin ##1 rail_enable[0]);
  override_cov: cover property (s_q.cpu_latch[OVERRIDE_BIT] ##1 s_q.step);
  fault_cov: cover property (regulator_fault_irq);

endmodule // bkrc_top
`default_nettype wire

// file: bkrc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Host side: register port and processor code pins
// ****************************************************************
module bkrc_host_model (
  input wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  output logic [6:0] voltage_code_bus,
  output logic [1:0] voltage_code_latch_enables,
  output logic standby_exit_pin
);
  // Idle levels from time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    voltage_code_bus = 7'h00;
    voltage_code_latch_enables = 2'b00;
    standby_exit_pin = 1'b0;
  end
  // One-byte write; released data shows its inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // One-byte read, data taken once the read edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Put a code on the shared bus and strobe one rail's enable
  task automatic latch(input logic [1:0] en, input logic [6:0] c);
    @(posedge clk_sys);
    voltage_code_bus <= c;
    voltage_code_latch_enables <= en;
    @(posedge clk_sys);
    voltage_code_latch_enables <= 2'b00;
    voltage_code_bus <= ~c;
  endtask
  // Standby exit request for one cycle
  task automatic exit_pulse();
    @(posedge clk_sys);
    standby_exit_pin <= 1'b1;
    @(posedge clk_sys);
    standby_exit_pin <= 1'b0;
  endtask
endmodule // bkrc_host_model
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bkrc_pkg::*;
  logic clk_sys, nrst, reg_wr, reg_rd, standby_exit_pin, adc_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, got;
  logic [6:0] voltage_code_bus, cpu_core_ref_code, gfx_core_ref_code;
  logic [1:0] voltage_code_latch_enables, adc_chan;
  logic [3:0] overcurrent_detect, v;
  logic [ADC_W-1:0] adc_data, memory_rail_current, preregulator_current, exp_mem, exp_pre;
  logic [2:0] rail_enable, rail_discharge;
  logic [5:0] rail_mode;
  logic [REF_W-1:0] cpu_core_ref_dmv, gfx_core_ref_dmv;
  logic cpu_core_overcurrent_flag, gfx_core_overcurrent_flag;
  logic memory_rail_overcurrent_flag, preregulator_overcurrent_flag, regulator_fault_irq;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  logic [1:0] em [3];
  logic [7:0] ctrl_addr [3] = '{8'h35, 8'h36, 8'h37};

  bkrc_top bkrc_top_inst (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .voltage_code_bus(voltage_code_bus),
    .voltage_code_latch_enables(voltage_code_latch_enables),
    .standby_exit_pin(standby_exit_pin), .overcurrent_detect(overcurrent_detect),
    .adc_valid(adc_valid), .adc_chan(adc_chan), .adc_data(adc_data),
    .rail_enable(rail_enable), .rail_mode(rail_mode), .rail_discharge(rail_discharge),
    .cpu_core_ref_code(cpu_core_ref_code), .cpu_core_ref_dmv(cpu_core_ref_dmv),
    .gfx_core_ref_code(gfx_core_ref_code), .gfx_core_ref_dmv(gfx_core_ref_dmv),
    .memory_rail_current(memory_rail_current), .preregulator_current(preregulator_current),
    .cpu_core_overcurrent_flag(cpu_core_overcurrent_flag),
    .gfx_core_overcurrent_flag(gfx_core_overcurrent_flag),
    .memory_rail_overcurrent_flag(memory_rail_overcurrent_flag),
    .preregulator_overcurrent_flag(preregulator_overcurrent_flag),
    .regulator_fault_irq(regulator_fault_irq));

  bkrc_host_model bkrc_host_model_inst (.clk_sys(clk_sys), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .voltage_code_bus(voltage_code_bus),
    .voltage_code_latch_enables(voltage_code_latch_enables),
    .standby_exit_pin(standby_exit_pin));

  // ****************************************************************
  // Clock, watchdog and checking helpers
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Whole run needs about 1200 cycles; a hang stops here
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Mode from a state code; reserved codes keep the old mode
  function automatic logic [1:0] next_mode(input logic [1:0] old, input logic [2:0] c);
    return c[2] ? c[1:0] : old;
  endfunction
  function automatic logic [13:0] dmv(input int c);
    return 14'(3000 + 125 * c);
  endfunction
  // Cycles until the chosen ramp output moves, bounded
  task automatic wait_step(input bit gfx, output int k);
    logic [6:0] s;
    s = gfx ? gfx_core_ref_code : cpu_core_ref_code;
    k = 0;
    while (k < 250 && (gfx ? gfx_core_ref_code : cpu_core_ref_code) === s) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
  endtask
  task automatic chk_rail(input int r);
    chk("rail_mode", 16'(em[r]), 16'(rail_mode[2*r +: 2]));
    chk("rail_enable", 16'(em[r] != 2'h0), 16'(rail_enable[r]));
    chk("rail_discharge", 16'(em[r] == 2'h0), 16'(rail_discharge[r]));
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    nrst = 1'b0;
    overcurrent_detect = 4'h0;
    adc_valid = 1'b0;
    adc_chan = 2'h0;
    adc_data = '0;
    exp_mem = '0;
    exp_pre = '0;
    em = '{2'h0, 2'h0, 2'h0};
    void'($urandom(32'h5598db49));
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    // Reset values, unmapped places read zero
    foreach (ctrl_addr[r]) begin
      bkrc_host_model_inst.rd(ctrl_addr[r], rv);
      chk("ctrl_reset", r == 0 ? 16'h24 : 16'h04, 16'(rv));
      chk_rail(r);
    end
    bkrc_host_model_inst.rd(8'h32, rv);
    chk("cpu_latch_reset", 16'h7f, 16'(rv));
    bkrc_host_model_inst.rd(8'h33, rv);
    chk("gfx_latch_reset", 16'h7f, 16'(rv));
    bkrc_host_model_inst.rd(8'h34, rv);
    chk("unmapped_read", 16'h00, 16'(rv));
    chk("cpu_ref_reset", 16'(dmv(72)), 16'(cpu_core_ref_dmv));
    // State codes, reserved codes and reserved top bits
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 12; i++) begin
        v = 4'($urandom);
        rv = {2'($urandom), 3'($urandom), i < 8 ? 3'(i) : 3'($urandom)};
        bkrc_host_model_inst.wr(ctrl_addr[r], rv);
        em[r] = next_mode(em[r], rv[2:0]);
        @(posedge clk_sys);
        #1;
        chk_rail(r);
        bkrc_host_model_inst.rd(ctrl_addr[r], got);
        chk("ctrl_readback", 16'(rv[5:0]), 16'(got));
      end
    end
    // Exit fields programmed by the host, then standby exit
    for (int r = 0; r < 3; r++) begin
      for (int x = 0; x < 8; x++) begin
        bkrc_host_model_inst.wr(ctrl_addr[r], {2'b00, 3'(x), ST_OFF});
        bkrc_host_model_inst.exit_pulse();
        em[r] = next_mode(2'h0, 3'(x));
        @(posedge clk_sys);
        #1;
        chk_rail(r);
        bkrc_host_model_inst.rd(ctrl_addr[r], rv);
        chk("exit_copy", 16'({3'(x), x > 3 ? 3'(x) : ST_OFF}), 16'(rv));
      end
    end
    // Over-current flags follow the detectors, any one raises the interrupt
    for (int i = 0; i < 16; i++) begin
      v = i < 4 ? 4'(1 << i) : 4'($urandom);
      @(posedge clk_sys);
      overcurrent_detect <= v;
      @(posedge clk_sys);
      #1;
      chk("fault_flags", 16'(v), 16'({preregulator_overcurrent_flag,
        memory_rail_overcurrent_flag, gfx_core_overcurrent_flag,
        cpu_core_overcurrent_flag}));
      chk("fault_irq", 16'(|v), 16'(regulator_fault_irq));
    end
    // Current samples land by channel; other channels leave them alone
    for (int c = 0; c < 4; c++) begin
      v = 4'(c);
      @(posedge clk_sys);
      adc_valid <= 1'b1;
      adc_chan <= 2'(c);
      adc_data <= 10'($urandom);
      @(posedge clk_sys);
      adc_valid <= 1'b0;
      @(posedge clk_sys);
      #1;
      // Only the addressed channel moves; the other keeps its last sample
      if (c == 0) exp_mem = adc_data;
      if (c == 1) exp_pre = adc_data;
      chk("mem_current", 16'(exp_mem), 16'(memory_rail_current));
      chk("pre_current", 16'(exp_pre), 16'(preregulator_current));
    end
    // Pin code ramps down with one step per slew tick
    bkrc_host_model_inst.latch(2'b01, 7'd70);
    #1;
    chk("ramp_not_instant", 16'd72, 16'(cpu_core_ref_code));
    wait_step(1'b0, n);
    wait_step(1'b0, n);
    chk("step_spacing", 16'(STEP_CYC), 16'(n));
    chk("cpu_ref_code", 16'd70, 16'(cpu_core_ref_code));
    chk("cpu_ref_dmv", 16'(dmv(70)), 16'(cpu_core_ref_dmv));
    bkrc_host_model_inst.rd(8'h32, rv);
    chk("code_hidden", 16'h7f, 16'(rv));
    // Register override wins over the pins
    bkrc_host_model_inst.wr(8'h32, 8'hc7);
    wait_step(1'b0, n);
    chk("ovr_ref", 16'd71, 16'(cpu_core_ref_code));
    bkrc_host_model_inst.latch(2'b01, 7'd16);
    repeat (150) @(posedge clk_sys);
    #1;
    chk("ovr_holds", 16'd71, 16'(cpu_core_ref_code));
    // Second rail takes the shared bus on its own enable
    bkrc_host_model_inst.latch(2'b10, 7'd71);
    wait_step(1'b1, n);
    chk("gfx_ref_dmv", 16'(dmv(71)), 16'(gfx_core_ref_dmv));
    chk("gfx_ref_code", 16'd71, 16'(gfx_core_ref_code));
    chk("cpu_untouched", 16'd71, 16'(cpu_core_ref_code));
    // Codes past the top step clamp to 1.2 V
    bkrc_host_model_inst.wr(8'h32, 8'hff);
    wait_step(1'b0, n);
    repeat (150) @(posedge clk_sys);
    #1;
    chk("clamp_dmv", 16'(dmv(72)), 16'(cpu_core_ref_dmv));
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
